// ==== hw/rcr_clock_gate.v ====
// Holds execution after reset release until a valid clock is handed over
`default_nettype none

module rcr_clock_gate #(
	parameter WAIT_CYCLES = 125
) (
	input  wire aclk,
	input  wire aresetn,
	input  wire sys_reset_active,
	input  wire clock_ready,
	input  wire monitor_en,
	output reg  core_run_reg,
	output reg  use_fast_rc_reg,
	output reg  fallback_pulse_reg
);

	// Last count before fallback, cut to the counter width on purpose
	localparam integer WAIT_LAST_INT = WAIT_CYCLES - 1;
	localparam [15:0]  WAIT_LAST     = WAIT_LAST_INT[15:0];
	reg [15:0] wait_cnt_reg;
	reg        checked_reg;

	// Release waits on a valid source; monitor checks once at release
	always @(posedge aclk)
	begin
		if (!aresetn)
		begin
			core_run_reg       <= 1'b0;
			use_fast_rc_reg    <= 1'b0;
			fallback_pulse_reg <= 1'b0;
			wait_cnt_reg       <= 16'h0000;
			checked_reg        <= 1'b0;
		end
		else if (sys_reset_active)
		begin
			core_run_reg       <= 1'b0;
			use_fast_rc_reg    <= 1'b0;
			fallback_pulse_reg <= 1'b0;
			wait_cnt_reg       <= 16'h0000;
			checked_reg        <= 1'b0;
		end
		else
		begin
			fallback_pulse_reg <= 1'b0;
			if (!checked_reg && monitor_en)
			begin
				// Monitoring starts at the moment of release
				if (clock_ready)
				begin
					checked_reg  <= 1'b1;
					core_run_reg <= 1'b1;
				end
				else if (wait_cnt_reg == WAIT_LAST)
				begin
					checked_reg        <= 1'b1;
					use_fast_rc_reg    <= 1'b1;
					fallback_pulse_reg <= 1'b1;
					core_run_reg       <= 1'b1;
				end
				else
					wait_cnt_reg <= wait_cnt_reg + 16'h0001;
			end
			else if (clock_ready || use_fast_rc_reg)
				core_run_reg <= 1'b1;
		end
	end

endmodule

`default_nettype wire

// ==== hw/rcr_event_latch.v ====
// Sticky event register: set wins over clear, read clears
`default_nettype none

module rcr_event_latch #(
	parameter W = 16
) (
	input  wire         aclk,
	input  wire         aresetn,
	input  wire [W-1:0] set_in,
	input  wire         clear_all,
	input  wire [W-1:0] mask_in,
	output reg  [W-1:0] status_reg,
	output reg          irq_reg
);

	reg [W-1:0] status_next;

	// New events survive a clearing read in the same cycle
	always @*
	begin
		status_next = (clear_all ? {W{1'b0}} : status_reg) | set_in;
	end

	// Status and level interrupt registers
	always @(posedge aclk)
	begin
		if (!aresetn)
		begin
			status_reg <= {W{1'b0}};
			irq_reg    <= 1'b0;
		end
		else
		begin
			status_reg <= status_next;
			irq_reg    <= |(status_next & mask_in);
		end
	end

endmodule

`default_nettype wire

// ==== hw/rcr_top.v ====
// Reset cause recorder with AXI4-Lite register slave
//
// Chosen here: the AXI4-Lite interface to the registers and the address map.
`include "rcr_map.vh"
`default_nettype none

module rcr_top #(
	parameter CLK_WAIT_CYCLES = (`RCR_CLK_WAIT_NS + `RCR_CLK_PERIOD_NS - 1) / `RCR_CLK_PERIOD_NS
) (
	input  wire        aclk,
	input  wire        aresetn,
	input  wire        por_event,
	input  wire        brownout_event,
	input  wire        pin_reset_event,
	input  wire        soft_reset_event,
	input  wire        watchdog_timeout,
	input  wire        trap_clash_event,
	input  wire        bad_op_event,
	input  wire        config_mismatch_event,
	input  wire        power_save_sleep,
	input  wire        power_save_idle,
	input  wire [1:0]  watchdog_fuse_enable,
	input  wire        system_reset_active,
	input  wire        clock_valid,
	input  wire [3:0]  s_axi_awaddr,
	input  wire        s_axi_awvalid,
	output reg         s_axi_awready,
	input  wire [31:0] s_axi_wdata,
	input  wire [3:0]  s_axi_wstrb,
	input  wire        s_axi_wvalid,
	output reg         s_axi_wready,
	output reg  [1:0]  s_axi_bresp,
	output reg         s_axi_bvalid,
	input  wire        s_axi_bready,
	input  wire [3:0]  s_axi_araddr,
	input  wire        s_axi_arvalid,
	output reg         s_axi_arready,
	output reg  [31:0] s_axi_rdata,
	output reg  [1:0]  s_axi_rresp,
	output reg         s_axi_rvalid,
	input  wire        s_axi_rready,
	output reg  [15:0] reset_cause_flags,
	output reg         watchdog_run_reg,
	output reg         core_run,
	output reg         use_fast_rc,
	output reg         irq
);

	// Offset check shared by both channels
	// Address bits 1:0 are ignored, so any byte address within a word selects it
	function is_reg;
		input [3:0] a;
		input [3:0] ofs;
		begin
			is_reg = (a[3:2] == ofs[3:2]);
		end
	endfunction

	// Software-visible state
	reg  [15:0] flags_reg;
	reg  [15:0] flags_next;
	reg  [15:0] irq_mask_reg;
	reg  [1:0]  control_reg;

	// Write channel holding registers; address and data may arrive apart
	reg  [3:0]  aw_addr_reg;
	reg         aw_have_reg;
	reg  [31:0] w_data_reg;
	reg  [3:0]  w_strb_reg;
	reg         w_have_reg;

	// Combinational helpers
	reg  [15:0] hw_set;
	reg  [15:0] wr_val;
	reg         wr_flags;
	reg         rd_status;

	// Outputs of the event latch and the clock gate
	wire [15:0] irq_status;
	wire        irq_level;
	wire        gate_run;
	wire        gate_fast_rc;
	wire        gate_fallback;

	// A write lands once both halves are held and the last response is gone
	wire wr_fire = aw_have_reg && w_have_reg && !s_axi_bvalid;
	// A read lands at its address handshake
	wire rd_fire = s_axi_arvalid && s_axi_arready;

	// Hardware cause vector; all coincident causes land together
	// Each cause is sampled as a level at the clock edge, so a cause that
	// stays high for several cycles keeps setting its flag every cycle
	always @*
	begin
		hw_set = 16'h0000;
		hw_set[`RCR_BIT_TRAP_CLASH] = trap_clash_event;
		hw_set[`RCR_BIT_BAD_OP]     = bad_op_event;
		hw_set[`RCR_BIT_CFG_MISM]   = config_mismatch_event;
		hw_set[`RCR_BIT_PIN_RESET]  = pin_reset_event;
		hw_set[`RCR_BIT_SOFT_RESET] = soft_reset_event;
		hw_set[`RCR_BIT_WDT_EXPIRY] = watchdog_timeout;
		hw_set[`RCR_BIT_SLEPT]      = power_save_sleep;
		hw_set[`RCR_BIT_IDLED]      = power_save_idle;
		hw_set[`RCR_BIT_BROWNOUT]   = brownout_event | por_event;
		hw_set[`RCR_BIT_POWER_ON]   = por_event;
	end

	// Byte-lane merge of a software write into the flags
	// Only the two low lanes carry flags; the upper lanes are ignored
	// An unstrobed lane keeps the current flag value
	always @*
	begin
		wr_val = flags_reg;
		if (w_strb_reg[0])
			wr_val[7:0] = w_data_reg[7:0];
		if (w_strb_reg[1])
			wr_val[15:8] = w_data_reg[15:8];
		wr_flags = wr_fire && is_reg(aw_addr_reg, `RCR_OFS_FLAGS);
	end

	// Flag update: power-on preset, then software, then hardware set
	// Power-on overrides everything, so a coincident cause is not recorded
	// Otherwise software goes first and hardware sets are merged last,
	// so an event never loses against a software write in the same cycle
	// The watchdog flag is cleared by a power-save entry unless a timeout
	// arrives in that same cycle
	always @*
	begin
		if (por_event)
			flags_next = `RCR_FLAGS_POR_VALUE;
		else
		begin
			flags_next = wr_flags ? (wr_val & `RCR_FLAGS_IMPL_MASK) : flags_reg;
			if (power_save_sleep || power_save_idle)
				flags_next[`RCR_BIT_WDT_EXPIRY] = 1'b0;
			flags_next = flags_next | hw_set;
		end
	end

	// Flags are not cleared by aresetn; only power-on presets them
	// A bus reset must keep the record of why the device last reset
	// The output port carries a registered copy of the same value
	always @(posedge aclk)
	begin
		flags_reg         <= flags_next;
		reset_cause_flags <= flags_next;
	end

	// Write address and data are taken independently
	// Each ready is a one-cycle pulse answering a valid seen the edge before
	// A held half is freed when its write lands, before the response is accepted,
	// so a new half may be taken while the last response is still pending
	// Offsets outside the four registers answer with a slave error
	always @(posedge aclk)
	begin
		if (!aresetn)
		begin
			aw_have_reg   <= 1'b0;
			w_have_reg    <= 1'b0;
			aw_addr_reg   <= 4'h0;
			w_data_reg    <= 32'h00000000;
			w_strb_reg    <= 4'h0;
			s_axi_awready <= 1'b0;
			s_axi_wready  <= 1'b0;
			s_axi_bvalid  <= 1'b0;
			s_axi_bresp   <= `RCR_OKAY;
		end
		else
		begin
			s_axi_awready <= !aw_have_reg && !s_axi_awready && s_axi_awvalid;
			s_axi_wready  <= !w_have_reg && !s_axi_wready && s_axi_wvalid;
			if (s_axi_awvalid && s_axi_awready)
			begin
				aw_have_reg <= 1'b1;
				aw_addr_reg <= s_axi_awaddr;
			end
			if (s_axi_wvalid && s_axi_wready)
			begin
				w_have_reg <= 1'b1;
				w_data_reg <= s_axi_wdata;
				w_strb_reg <= s_axi_wstrb;
			end
			if (wr_fire)
			begin
				aw_have_reg  <= 1'b0;
				w_have_reg   <= 1'b0;
				s_axi_bvalid <= 1'b1;
				if (is_reg(aw_addr_reg, `RCR_OFS_FLAGS) || is_reg(aw_addr_reg, `RCR_OFS_IRQ_STATUS)
					|| is_reg(aw_addr_reg, `RCR_OFS_IRQ_MASK) || is_reg(aw_addr_reg, `RCR_OFS_CONTROL))
					s_axi_bresp <= `RCR_OKAY;
				else
					s_axi_bresp <= `RCR_SLVERR;
			end
			else if (s_axi_bvalid && s_axi_bready)
				s_axi_bvalid <= 1'b0;
		end
	end

	// Mask and control registers written by software
	// Control bit 0 is the soft watchdog enable, bit 1 the clock monitor enable
	always @(posedge aclk)
	begin
		if (!aresetn)
		begin
			irq_mask_reg <= 16'h0000;
			control_reg  <= 2'h0;
		end
		else if (wr_fire)
		begin
			if (is_reg(aw_addr_reg, `RCR_OFS_IRQ_MASK))
			begin
				if (w_strb_reg[0])
					irq_mask_reg[7:0] <= w_data_reg[7:0];
				if (w_strb_reg[1])
					irq_mask_reg[15:8] <= w_data_reg[15:8];
			end
			else if (is_reg(aw_addr_reg, `RCR_OFS_CONTROL) && w_strb_reg[0])
				control_reg <= w_data_reg[1:0];
		end
	end

	// Read channel: one read at a time, status cleared by its read
	// Read data are captured at the address handshake and stand with rvalid
	// until rready; the next address is not taken while rvalid is high
	// Control reads also return watchdog run, fast RC select and core run
	// Unmapped offsets read as zero with a slave error
	always @(posedge aclk)
	begin
		if (!aresetn)
		begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid  <= 1'b0;
			s_axi_rdata   <= 32'h00000000;
			s_axi_rresp   <= `RCR_OKAY;
		end
		else
		begin
			s_axi_arready <= !s_axi_arready && !s_axi_rvalid && s_axi_arvalid;
			if (rd_fire)
			begin
				s_axi_rvalid <= 1'b1;
				s_axi_rresp  <= `RCR_OKAY;
				if (is_reg(s_axi_araddr, `RCR_OFS_FLAGS))
					s_axi_rdata <= {16'h0000, flags_reg};
				else if (is_reg(s_axi_araddr, `RCR_OFS_IRQ_STATUS))
					s_axi_rdata <= {16'h0000, irq_status};
				else if (is_reg(s_axi_araddr, `RCR_OFS_IRQ_MASK))
					s_axi_rdata <= {16'h0000, irq_mask_reg};
				else if (is_reg(s_axi_araddr, `RCR_OFS_CONTROL))
					s_axi_rdata <= {24'h000000, core_run, use_fast_rc, watchdog_run_reg,
						3'h0, control_reg};
				else
				begin
					s_axi_rdata <= 32'h00000000;
					s_axi_rresp <= `RCR_SLVERR;
				end
			end
			else if (s_axi_rvalid && s_axi_rready)
				s_axi_rvalid <= 1'b0;
		end
	end

	// A read of the event status register clears it in the same cycle
	always @*
	begin
		rd_status = rd_fire && is_reg(s_axi_araddr, `RCR_OFS_IRQ_STATUS);
	end

	// Interrupt events: each hardware cause, plus clock fallback on bit 5
	// The event status shares the flag layout; bit 5 is free there
	// A clearing read never hides an event that lands in the same cycle
	rcr_event_latch #(
		.W(16)
	) u_events (
		.aclk       (aclk),
		.aresetn    (aresetn),
		.set_in     (hw_set | {10'h000, gate_fallback, 5'h00}),
		.clear_all  (rd_status),
		.mask_in    (irq_mask_reg),
		.status_reg (irq_status),
		.irq_reg    (irq_level)
	);

	// Execution hold and clock monitor, independent of reset delays
	// Oscillator readiness arrives on its own input, so reset release may
	// come before any clock is usable
	// Without the monitor, the core waits for a valid clock indefinitely
	rcr_clock_gate #(
		.WAIT_CYCLES(CLK_WAIT_CYCLES)
	) u_clock (
		.aclk               (aclk),
		.aresetn            (aresetn),
		.sys_reset_active   (system_reset_active),
		.clock_ready        (clock_valid),
		.monitor_en         (control_reg[`RCR_CTRL_MON_EN]),
		.core_run_reg       (gate_run),
		.use_fast_rc_reg    (gate_fast_rc),
		.fallback_pulse_reg (gate_fallback)
	);

	// Output registers: watchdog run, execution hold, oscillator select, irq
	// An unprogrammed fuse field forces the watchdog on whatever software says
	// Gate and latch outputs pass one more register, adding a cycle of lag
	always @(posedge aclk)
	begin
		if (!aresetn)
		begin
			watchdog_run_reg <= 1'b0;
			core_run         <= 1'b0;
			use_fast_rc      <= 1'b0;
			irq              <= 1'b0;
		end
		else
		begin
			watchdog_run_reg <= (watchdog_fuse_enable == `RCR_FUSE_WDT_UNPROG)
				|| control_reg[`RCR_CTRL_WDT_SOFT_EN];
			core_run         <= gate_run;
			use_fast_rc      <= gate_fast_rc;
			irq              <= irq_level;
		end
	end

endmodule

`default_nettype wire

// ==== pkg/rcr_map.vh ====
// Register map, field positions and timing counts of the reset cause recorder
`ifndef RCR_MAP_VH
`define RCR_MAP_VH

`define RCR_OFS_FLAGS      4'h0
`define RCR_OFS_IRQ_STATUS 4'h4
`define RCR_OFS_IRQ_MASK   4'h8
`define RCR_OFS_CONTROL    4'hc
`define RCR_OFS_CLK_STATUS 4'h0 + 4'h0

`define RCR_BIT_TRAP_CLASH  15
`define RCR_BIT_BAD_OP      14
`define RCR_BIT_CFG_MISM    9
`define RCR_BIT_PIN_RESET   7
`define RCR_BIT_SOFT_RESET  6
`define RCR_BIT_WDT_EXPIRY  4
`define RCR_BIT_SLEPT       3
`define RCR_BIT_IDLED       2
`define RCR_BIT_BROWNOUT    1
`define RCR_BIT_POWER_ON    0

`define RCR_FLAGS_IMPL_MASK 16'hc2df
`define RCR_FLAGS_POR_VALUE 16'h0003

`define RCR_CTRL_WDT_SOFT_EN 0
`define RCR_CTRL_MON_EN      1

`define RCR_FUSE_WDT_UNPROG  2'h3

`define RCR_SLVERR           2'h2
`define RCR_OKAY             2'h0

`define RCR_CLK_WAIT_NS      1000
`define RCR_CLK_PERIOD_NS    8

`endif

// ==== sim/rcr_chk_assertions.sv ====
// Port-level checks for the reset cause recorder
`default_nettype none
module rcr_chk (
	input wire logic        aclk,
	input wire logic        aresetn,
	input wire logic        por_event,
	input wire logic        trap_clash_event,
	input wire logic        bad_op_event,
	input wire logic        config_mismatch_event,
	input wire logic        pin_reset_event,
	input wire logic        power_save_sleep,
	input wire logic        power_save_idle,
	input wire logic        watchdog_timeout,
	input wire logic [1:0]  watchdog_fuse_enable,
	input wire logic        clock_valid,
	input wire logic        s_axi_wvalid,
	input wire logic        s_axi_wready,
	input wire logic [15:0] reset_cause_flags,
	input wire logic        watchdog_run_reg,
	input wire logic        core_run,
	input wire logic        use_fast_rc
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking cb @(posedge aclk);
	endclocking
	default disable iff (!aresetn);
	// A cause event without power-on leaves its flag set next cycle
	property p_set(ev, b);
		ev && !por_event |=> b;
	endproperty
	// Three cycles with no valid clock
	sequence s_noclk;
		!clock_valid [*3];
	endsequence
	a_por_preset: assert property (por_event |=> reset_cause_flags == 16'h0003)
		else $error("power-on preset wrong");
	a_trap_set: assert property (p_set(trap_clash_event, reset_cause_flags[15]))
		else $error("trap flag not set");
	a_badop_set: assert property (p_set(bad_op_event, reset_cause_flags[14]))
		else $error("bad op flag not set");
	a_cfg_set: assert property (p_set(config_mismatch_event, reset_cause_flags[9]))
		else $error("config flag not set");
	a_pin_set: assert property (p_set(pin_reset_event, reset_cause_flags[7]))
		else $error("pin flag not set");
	a_sleep_set: assert property (p_set(power_save_sleep, reset_cause_flags[3]))
		else $error("slept flag not set");
	a_wdt_clear: assert property ((power_save_sleep || power_save_idle) && !watchdog_timeout && !por_event
		&& !s_axi_wvalid && !s_axi_wready |=> !reset_cause_flags[4]) else $error("watchdog flag kept");
	a_fuse_run: assert property (watchdog_fuse_enable == 2'h3 |=> watchdog_run_reg)
		else $error("watchdog not running");
	// A held core starts only on a valid clock or together with the fallback
	a_core_hold: assert property (s_noclk ##0 !core_run ##0 !use_fast_rc |=> !core_run || use_fast_rc)
		else $error("core runs without clock");
endmodule
bind rcr_top rcr_chk u_chk (
	.aclk                  (aclk),
	.aresetn               (aresetn),
	.por_event             (por_event),
	.trap_clash_event      (trap_clash_event),
	.bad_op_event          (bad_op_event),
	.config_mismatch_event (config_mismatch_event),
	.pin_reset_event       (pin_reset_event),
	.power_save_sleep      (power_save_sleep),
	.power_save_idle       (power_save_idle),
	.watchdog_timeout      (watchdog_timeout),
	.watchdog_fuse_enable  (watchdog_fuse_enable),
	.clock_valid           (clock_valid),
	.s_axi_wvalid          (s_axi_wvalid),
	.s_axi_wready          (s_axi_wready),
	.reset_cause_flags     (reset_cause_flags),
	.watchdog_run_reg      (watchdog_run_reg),
	.core_run              (core_run),
	.use_fast_rc           (use_fast_rc)
);
`default_nettype wire

// ==== sim/testbench.sv ====
// Self-checking bench for the reset cause recorder
`default_nettype none
module testbench;
	timeunit 1ns;
	timeprecision 1ps;
	logic        aclk = 0, aresetn = 0, system_reset_active = 1, clock_valid = 0;
	logic [9:0]  ev = 10'h000;
	logic [1:0]  watchdog_fuse_enable = 2'h0;
	logic [3:0]  s_axi_awaddr = 4'h0, s_axi_araddr = 4'h0, s_axi_wstrb = 4'hf;
	logic [31:0] s_axi_wdata = 32'h0;
	logic        s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0, s_axi_arvalid = 0, s_axi_rready = 0;
	wire         por_event, brownout_event, pin_reset_event, soft_reset_event, watchdog_timeout;
	wire         trap_clash_event, bad_op_event, config_mismatch_event, power_save_sleep, power_save_idle;
	wire         s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
	wire         watchdog_run_reg, core_run, use_fast_rc, irq;
	wire [1:0]   s_axi_bresp, s_axi_rresp;
	wire [31:0]  s_axi_rdata;
	wire [15:0]  reset_cause_flags;
	int          err_total = 0, tests_run = 0, n;
	int          fb [9] = '{2, 3, 9, 14, 15, 4, 6, 7, 1};
	// Event vector to cause inputs
	assign {por_event, brownout_event, pin_reset_event, soft_reset_event, watchdog_timeout, trap_clash_event,
		bad_op_event, config_mismatch_event, power_save_sleep, power_save_idle} = ev;
	rcr_top #(.CLK_WAIT_CYCLES(4)) uut (.*);
	always #4 aclk = ~aclk;
	task automatic chk(input logic [31:0] g, input logic [31:0] e);
		tests_run++;
		if (g !== e)
		begin
			err_total++;
			$display("[ERR] %0t got %h exp %h", $time, g, e);
		end
	endtask
	task automatic cyc(input int k);
		repeat (k) @(posedge aclk);
	endtask
	// Register write: address and data offered together
	task automatic wr(input logic [3:0] a, input logic [31:0] d);
		@(posedge aclk);
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_awvalid <= 1;
		s_axi_wvalid <= 1;
		s_axi_bready <= 1;
		do
		begin
			@(posedge aclk);
			if (s_axi_awready) s_axi_awvalid <= 0;
			if (s_axi_wready) s_axi_wvalid <= 0;
		end
		while (s_axi_bvalid !== 1'b1);
		s_axi_bready <= 0;
		chk({30'h0, s_axi_bresp}, 32'h0);
	endtask
	// Register read with expected word
	task automatic rd(input logic [3:0] a, input logic [31:0] e);
		@(posedge aclk);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1;
		s_axi_rready <= 1;
		do
		begin
			@(posedge aclk);
			if (s_axi_arready) s_axi_arvalid <= 0;
		end
		while (s_axi_rvalid !== 1'b1);
		s_axi_rready <= 0;
		chk(s_axi_rdata, e);
		chk({30'h0, s_axi_rresp}, 32'h0);
	endtask
	task automatic pulse(input logic [9:0] v);
		@(posedge aclk);
		ev <= v;
		@(posedge aclk);
		ev <= 10'h000;
	endtask
	task automatic print_verdict;
		$display("checks %0d errors %0d", tests_run, err_total);
		if (err_total == 0 && tests_run > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask
	// Watchdog against a hang
	initial
	begin
		#50000;
		err_total++;
		print_verdict();
	end
	// Main sequence
	initial
	begin
		cyc(2);
		aresetn <= 1;
		wr(4'h8, 32'h80);
		pulse(10'h040);
		cyc(2);
		chk(irq, 1'b0);
		pulse(10'h080);
		cyc(2);
		chk(irq, 1'b1);
		rd(4'h4, 32'hc0);
		cyc(2);
		chk(irq, 1'b0);
		pulse(10'h200);
		rd(4'h0, 32'h3);
		chk(reset_cause_flags, 16'h0003);
		for (int i = 0; i < 9; i++)
		begin
			wr(4'h0, 32'h0);
			pulse(10'h001 << i);
			rd(4'h0, 32'h1 << fb[i]);
		end
		wr(4'h0, 32'h10);
		pulse(10'h002);
		rd(4'h0, 32'h8);
		pulse(10'h021);
		rd(4'h0, 32'h1c);
		wr(4'h0, 32'h0);
		pulse(10'h0d0);
		rd(4'h0, 32'h80c0);
		pulse(10'h210);
		rd(4'h0, 32'h3);
		wr(4'h0, 32'hffffffff);
		rd(4'h0, 32'hc2df);
		watchdog_fuse_enable <= 2'h3;
		cyc(2);
		chk(watchdog_run_reg, 1'b1);
		watchdog_fuse_enable <= 2'h0;
		cyc(2);
		chk(watchdog_run_reg, 1'b0);
		wr(4'hc, 32'h1);
		cyc(2);
		chk(watchdog_run_reg, 1'b1);
		rd(4'hc, 32'h21);
		system_reset_active <= 0;
		cyc(10);
		chk(core_run, 1'b0);
		clock_valid <= 1;
		cyc(4);
		chk(core_run, 1'b1);
		clock_valid <= 0;
		system_reset_active <= 1;
		wr(4'hc, 32'h2);
		wr(4'h8, 32'h20);
		system_reset_active <= 0;
		n = 0;
		while (use_fast_rc !== 1'b1 && n < 40)
		begin
			cyc(1);
			n++;
		end
		chk(32'(n >= 4 && n < 12), 32'h1);
		cyc(2);
		chk(core_run, 1'b1);
		chk(irq, 1'b1);
		print_verdict();
	end
endmodule
`default_nettype wire
